/* design/ssdc_top.v */
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ssdc_defs.vh"

// What this block does
// [R1] One delay code equals one input half-cycle.
// [R2] Follower waits seven input pulses before starting.
// [R3] Software adds follower offset to controller outputs.
// [R4] Software delays device clocks by slowest divide.
// [R5] Software sets SYSREF delay one half-period early.
// [R6] Software aligns pass-through with latest SYSREF.
// [R7] Routing bit three drives level-good onto status.
// [R8] Software writes zero to block power register.
// [R9] Software sets full power during setup.
// [R10] Role bit: zero controller, one follower.
// [R11] Mode bit: zero sync, one SYSREF request.
// [R12] Pulsed outputs emit two-power-exponent pulses.
// [R13] Software request bit stays low while configuring.
// [R14] Dividers hold for programmed delay after sync.
// [R15] Software syncs before any SYSREF request.
// [R16] Function select: clock, SYSREF, pass-through, pulsed.
// [R17] Software request held at least one millisecond.
// [R18] Pulsed outputs burst then return low.
module ssdc_top
(
	input  wire        clk_in,
	input  wire        rst_n_in,
	input  wire [7:0]  addr_in,
	input  wire [7:0]  wdata_in,
	input  wire        wr_in,
	input  wire        rd_in,
	output reg  [7:0]  rdata_out,
	input  wire        sync_request_input_in,
	input  wire        input_level_good_flag_in,
	output reg         stat_out,
	output reg  [10:0] clk_out,
	output wire        irq_out
);

	// Slot number of an address inside the per-output register window.
	function [1:0] ssdc_slot;
		input [7:0] a;
		reg   [7:0] off;
		begin
			off = a - `SSDC_A_OUT_BASE;
			ssdc_slot = off[1:0];
		end
	endfunction

	// Output index of an address inside the per-output register window.
	function [3:0] ssdc_index;
		input [7:0] a;
		reg   [7:0] off;
		begin
			off = a - `SSDC_A_OUT_BASE;
			ssdc_index = off[5:2];
		end
	endfunction

	// Two-bit power level of output n from the three packed registers.
	function [1:0] ssdc_pwr;
		input [23:0] p;
		input [3:0]  n;
		reg   [4:0]  b;
		begin
			b = {n, 1'b0};
			ssdc_pwr = p[b +: 2];
		end
	endfunction

	reg  [7:0]  status_pin_routing;
	reg  [7:0]  block_power_and_filter;
	reg  [7:0]  output_power_level_a;
	reg  [7:0]  output_power_level_b;
	reg  [7:0]  output_power_level_c;
	reg  [7:0]  sync_sysref_global_modes;
	reg  [7:0]  out_divide   [0:10];
	reg  [7:0]  out_control  [0:10];
	reg  [7:0]  out_delay_lo [0:10];
	reg  [2:0]  irq_status;
	reg  [2:0]  irq_enable;
	reg  [2:0]  req_sync;
	reg  [2:0]  lvl_sync;
	reg         req_level;
	reg         lvl_level;
	reg         req_prev;
	reg  [7:0]  div_cnt      [0:10];
	reg  [11:0] hold_cnt     [0:10];
	reg  [10:0] waiting;
	reg  [10:0] running;
	reg  [10:0] phase;
	reg  [8:0]  burst_left   [0:10];
	reg  [10:0] burst_end;
	reg  [7:0]  next_rdata;
	reg  [2:0]  irq_event;
	wire        in_window;
	wire [1:0]  slot;
	wire [3:0]  index;
	wire        chain_role_select;
	wire        request_mode_select;
	wire        software_request_bit;
	wire [2:0]  pulse_count_exponent;
	wire [23:0] pwr_packed;
	wire        req_any;
	wire        req_rise;
	wire        sync_start;
	wire        sysref_start;
	wire [8:0]  burst_pulses;
	wire [11:0] role_extra;
	// Each clocked process owns its own loop index, so no variable has two drivers.
	integer     i;
	integer     j;
	integer     k;

	assign in_window = (addr_in >= `SSDC_A_OUT_BASE) && (addr_in <= `SSDC_A_OUT_LAST);
	assign slot      = ssdc_slot(addr_in);
	assign index     = ssdc_index(addr_in);

	// Global mode fields.
	assign chain_role_select    = sync_sysref_global_modes[`SSDC_MD_ROLE];
	assign request_mode_select  = sync_sysref_global_modes[`SSDC_MD_REQMODE];
	assign software_request_bit = sync_sysref_global_modes[`SSDC_MD_SWREQ];
	assign pulse_count_exponent = sync_sysref_global_modes[`SSDC_MD_EXP_HI:`SSDC_MD_EXP_LO];
	assign pwr_packed = {output_power_level_c, output_power_level_b, output_power_level_a};

	// Request is the pin or the software bit; only a rising edge starts anything.
	assign req_any      = req_level | software_request_bit;
	assign req_rise     = req_any & ~req_prev;
	assign sync_start   = req_rise & ~request_mode_select; // [R11]
	assign sysref_start = req_rise & request_mode_select;  // [R11]
	// Pulse count is a power of two; the count is in pulses.
	assign burst_pulses = `SSDC_ONE9 << pulse_count_exponent; // [R12]
	// A follower waits seven input periods, fourteen half-cycles, before starting.
	assign role_extra = chain_role_select ? `SSDC_FOLLOW_HOLD : 12'h000; // [R2] [R10]

	assign irq_out = |(irq_status & irq_enable);

	// Pin inputs pass three flops; a level changes once stages two and three agree.
	always @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			req_sync  <= 3'h0;
			lvl_sync  <= 3'h0;
			req_level <= 1'b0;
			lvl_level <= 1'b0;
			req_prev  <= 1'b0;
		end
		else
		begin
			req_sync <= {req_sync[1:0], sync_request_input_in};
			lvl_sync <= {lvl_sync[1:0], input_level_good_flag_in};
			if (req_sync[1] == req_sync[2])
				req_level <= req_sync[2];
			if (lvl_sync[1] == lvl_sync[2])
				lvl_level <= lvl_sync[2];
			req_prev <= req_any;
		end
	end

	// Register writes.
	always @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			status_pin_routing       <= `SSDC_RST_BYTE;
			block_power_and_filter   <= `SSDC_RST_BYTE;
			output_power_level_a     <= `SSDC_RST_BYTE;
			output_power_level_b     <= `SSDC_RST_BYTE;
			output_power_level_c     <= `SSDC_RST_BYTE;
			sync_sysref_global_modes <= `SSDC_RST_BYTE;
			irq_enable               <= 3'h0;
			for (j = 0; j < `SSDC_NOUT; j = j + 1)
			begin
				out_divide[j]   <= `SSDC_RST_DIV;
				out_control[j]  <= `SSDC_RST_BYTE;
				out_delay_lo[j] <= `SSDC_RST_BYTE;
			end
		end
		else if (wr_in)
		begin
			case (addr_in)
				`SSDC_A_ROUTE:  status_pin_routing       <= wdata_in;
				`SSDC_A_BLKPWR: block_power_and_filter   <= wdata_in;
				`SSDC_A_PWR_A:  output_power_level_a     <= wdata_in;
				`SSDC_A_PWR_B:  output_power_level_b     <= wdata_in;
				`SSDC_A_PWR_C:  output_power_level_c     <= wdata_in;
				`SSDC_A_MODES:  sync_sysref_global_modes <= wdata_in;
				`SSDC_A_IRQ_EN: irq_enable               <= wdata_in[2:0];
				default:
				begin
					if (in_window)
					begin
						case (slot)
							`SSDC_SLOT_DIV: out_divide[index]   <= wdata_in;
							`SSDC_SLOT_CTL: out_control[index]  <= wdata_in;
							`SSDC_SLOT_DLO: out_delay_lo[index] <= wdata_in;
							default:        ;
						endcase
					end
				end
			endcase
		end
	end

	// Read data registered for the cycle after the strobe; unmapped reads give zero.
	always @*
	begin
		next_rdata = 8'h00;
		case (addr_in)
			`SSDC_A_ROUTE:    next_rdata = status_pin_routing;
			`SSDC_A_BLKPWR:   next_rdata = block_power_and_filter;
			`SSDC_A_PWR_A:    next_rdata = output_power_level_a;
			`SSDC_A_PWR_B:    next_rdata = output_power_level_b;
			`SSDC_A_PWR_C:    next_rdata = output_power_level_c;
			`SSDC_A_MODES:    next_rdata = sync_sysref_global_modes;
			`SSDC_A_IRQ_STAT: next_rdata = {5'h00, irq_status};
			`SSDC_A_IRQ_EN:   next_rdata = {5'h00, irq_enable};
			default:
			begin
				if (in_window)
				begin
					case (slot)
						`SSDC_SLOT_DIV: next_rdata = out_divide[index];
						`SSDC_SLOT_CTL: next_rdata = out_control[index];
						`SSDC_SLOT_DLO: next_rdata = out_delay_lo[index];
						default:        next_rdata = 8'h00;
					endcase
				end
			end
		endcase
	end

	always @(posedge clk_in)
	begin
		if (!rst_n_in)
			rdata_out <= 8'h00;
		else if (rd_in)
			rdata_out <= next_rdata;
	end

	// Interrupt events; a new event wins over a clear in the same cycle.
	always @*
	begin
		irq_event = 3'h0;
		irq_event[`SSDC_IRQ_SYNC]    = sync_start;
		irq_event[`SSDC_IRQ_BURST]   = |burst_end;
		irq_event[`SSDC_IRQ_LVLLOST] = lvl_sync[2] == lvl_sync[1] && !lvl_sync[2] && lvl_level;
	end

	always @(posedge clk_in)
	begin
		if (!rst_n_in)
			irq_status <= 3'h0;
		else if (wr_in && addr_in == `SSDC_A_IRQ_CLR)
			irq_status <= (irq_status & ~wdata_in[2:0]) | irq_event;
		else
			irq_status <= irq_status | irq_event;
	end

	// Status pin follows the level-good flag when routed.
	always @(posedge clk_in)
	begin
		if (!rst_n_in)
			stat_out <= 1'b0;
		else
			stat_out <= status_pin_routing[`SSDC_ROUTE_LVL] & lvl_level; // [R7]
	end

	// Output dividers; one clk_in tick stands for one input half-cycle.
	always @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			waiting   <= 11'h000;
			running   <= 11'h7ff;
			phase     <= 11'h000;
			burst_end <= 11'h000;
			for (i = 0; i < `SSDC_NOUT; i = i + 1)
			begin
				div_cnt[i]    <= 8'h00;
				hold_cnt[i]   <= 12'h000;
				burst_left[i] <= 9'h000;
			end
		end
		else
		begin
			for (i = 0; i < `SSDC_NOUT; i = i + 1)
			begin
				burst_end[i] <= 1'b0;
				if (sync_start && out_control[i][`SSDC_CTL_REQEN])
				begin
					// Stop, then hold for delay word plus role offset.
					running[i]    <= 1'b0;
					waiting[i]    <= 1'b1;
					phase[i]      <= 1'b0;
					div_cnt[i]    <= 8'h00;
					burst_left[i] <= 9'h000;
					hold_cnt[i]   <= {out_control[i][`SSDC_CTL_DHI_HI:0], out_delay_lo[i]}
						+ role_extra; // [R1] [R14] [R2]
				end
				else if (waiting[i])
				begin
					if (hold_cnt[i] == 12'h000)
					begin
						waiting[i] <= 1'b0;
						running[i] <= block_power_and_filter == `SSDC_RST_BYTE;
					end
					else
						hold_cnt[i] <= hold_cnt[i] - `SSDC_ONE12; // [R14]
				end
				else
				begin
					if (!running[i])
						running[i] <= block_power_and_filter == `SSDC_RST_BYTE;
					else if (div_cnt[i] + `SSDC_ONE8 >= out_divide[i])
					begin
						// Toggle every divide half-cycles: period is divide input cycles.
						div_cnt[i] <= 8'h00;
						phase[i]   <= ~phase[i];
						if (phase[i] && burst_left[i] != 9'h000)
						begin
							burst_left[i] <= burst_left[i] - `SSDC_ONE9; // [R18]
							if (burst_left[i] == `SSDC_ONE9)
								burst_end[i] <= 1'b1;
						end
					end
					else
						div_cnt[i] <= div_cnt[i] + `SSDC_ONE8;
					if (sysref_start && out_control[i][`SSDC_CTL_REQEN]
						&& out_control[i][`SSDC_CTL_FN_HI:`SSDC_CTL_FN_LO] == `SSDC_FN_PULSED)
						burst_left[i] <= burst_pulses; // [R12] [R18]
				end
			end
		end
	end

	// Output pins by function and power level; powered-down outputs sit low.
	always @(posedge clk_in)
	begin
		if (!rst_n_in)
			clk_out <= 11'h000;
		else
		begin
			for (k = 0; k < `SSDC_NOUT; k = k + 1)
			begin
				if (ssdc_pwr(pwr_packed, k[3:0]) != 2'h0 || !running[k])
					clk_out[k] <= 1'b0;
				else
				begin
					case (out_control[k][`SSDC_CTL_FN_HI:`SSDC_CTL_FN_LO]) // [R16]
						`SSDC_FN_CLOCK:  clk_out[k] <= phase[k];
						`SSDC_FN_SYSREF: clk_out[k] <= phase[k];
						`SSDC_FN_PASS:   clk_out[k] <= req_any;
						`SSDC_FN_PULSED: clk_out[k] <= phase[k] & (burst_left[k] != 9'h000);
						default:         clk_out[k] <= 1'b0;
					endcase
				end
			end
		end
	end

endmodule // ssdc_top
`default_nettype wire

/* design/ssdc_defs.vh */
`ifndef SSDC_DEFS_VH
`define SSDC_DEFS_VH

// Register addresses.
`define SSDC_A_ROUTE      8'h01
`define SSDC_A_BLKPWR     8'h02
`define SSDC_A_PWR_A      8'h03
`define SSDC_A_PWR_B      8'h04
`define SSDC_A_PWR_C      8'h05
`define SSDC_A_MODES      8'h0b
`define SSDC_A_OUT_BASE   8'h0c
`define SSDC_A_OUT_LAST   8'h37
`define SSDC_A_IRQ_STAT   8'h38
`define SSDC_A_IRQ_CLR    8'h39
`define SSDC_A_IRQ_EN     8'h3a

// Output count and per-output register slots.
`define SSDC_NOUT         11
`define SSDC_SLOT_DIV     2'h0
`define SSDC_SLOT_CTL     2'h1
`define SSDC_SLOT_DLO     2'h2

// Field positions.
`define SSDC_ROUTE_LVL    3
`define SSDC_MD_SWREQ     0
`define SSDC_MD_EXP_HI    3
`define SSDC_MD_EXP_LO    1
`define SSDC_MD_ROLE      4
`define SSDC_MD_REQMODE   5
`define SSDC_CTL_REQEN    7
`define SSDC_CTL_FN_HI    5
`define SSDC_CTL_FN_LO    4
`define SSDC_CTL_DHI_HI   3

// Output functions.
`define SSDC_FN_CLOCK     2'h0
`define SSDC_FN_SYSREF    2'h1
`define SSDC_FN_PASS      2'h2
`define SSDC_FN_PULSED    2'h3

// Interrupt bits.
`define SSDC_IRQ_SYNC     0
`define SSDC_IRQ_BURST    1
`define SSDC_IRQ_LVLLOST  2

// Reset values and timing counts.
`define SSDC_RST_BYTE     8'h00
`define SSDC_RST_DIV      8'h01
`define SSDC_FOLLOW_HOLD  12'h00e
`define SSDC_ONE12        12'h001
`define SSDC_ONE8         8'h01
`define SSDC_ONE9         9'h001

`endif

/* tb/ssdc_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ssdc_checker (
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       wr_in,
	input wire logic       rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic       input_level_good_flag_in,
	input wire logic       stat_out,
	input wire logic       irq_out
);
	logic [7:0] route_sh;
	logic [7:0] modes_sh;
	logic [7:0] en_sh;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// Shadow copies of the registers that the checks depend on.
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			route_sh <= 8'h00;
			modes_sh <= 8'h00;
			en_sh <= 8'h00;
		end
		else if (wr_in)
			case (addr_in)
			8'h01: route_sh <= wdata_in;
			8'h0b: modes_sh <= wdata_in;
			8'h3a: en_sh <= wdata_in;
			default: ;
			endcase
	end
	// The flag must have been good for a while before the pin may follow it.
	sequence s_level_good;
		(route_sh[3] && input_level_good_flag_in) [*8];
	endsequence
	// Bus answers, status pin and interrupt relations.
	chk_unmapped_read: assert property (rd_in && addr_in == 8'h06 |=> rdata_out == 8'h00)
		else $error("unmapped read not zero");
	chk_route_read: assert property (rd_in && addr_in == 8'h01 |=> rdata_out == route_sh)
		else $error("routing readback wrong");
	chk_modes_read: assert property (rd_in && addr_in == 8'h0b |=> rdata_out == modes_sh)
		else $error("modes readback wrong");
	chk_read_hold: assert property (!rd_in |=> $stable(rdata_out))
		else $error("read data moved without a read");
	chk_irq_masked: assert property (en_sh == 8'h00 |-> !irq_out)
		else $error("interrupt high while all masked");
	chk_irq_cause: assert property (irq_out && rd_in && addr_in == 8'h38 |=> (rdata_out & en_sh) != 8'h00)
		else $error("interrupt without enabled status");
	chk_stat_off: assert property (!route_sh[3] [*2] |-> !stat_out)
		else $error("status pin high while routing off");
	chk_stat_on: assert property (s_level_good |-> stat_out)
		else $error("status pin stayed low");
	chk_level_lost: assert property ($fell(input_level_good_flag_in) && en_sh[2] |-> ##[1:10] irq_out)
		else $error("level loss raised no interrupt");
endmodule // ssdc_checker
bind ssdc_top ssdc_checker ssdc_checker_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.rdata_out(rdata_out), .input_level_good_flag_in(input_level_good_flag_in),
	.stat_out(stat_out), .irq_out(irq_out));
`default_nettype wire

/* tb/ssdc_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module ssdc_partner (
	input wire logic        clk_in,
	input wire logic        clear_in,
	input wire logic [3:0]  sel_in,
	input wire logic [10:0] lines_in,
	output logic     [15:0] rises_out,
	output logic     [15:0] first_out
);
	logic [15:0] age;
	logic        prev;
	// Counts rising edges on the watched line, noting when the first came.
	always @(posedge clk_in)
	begin
		prev <= lines_in[sel_in];
		age <= clear_in ? 16'h0000 : age + 16'h0001;
		if (clear_in)
		begin
			rises_out <= 16'h0000;
			first_out <= 16'hffff;
		end
		else if (lines_in[sel_in] && !prev)
		begin
			rises_out <= rises_out + 16'h0001;
			if (rises_out == 16'h0000)
				first_out <= age;
		end
	end
endmodule // ssdc_partner
`default_nettype wire

/* tb/sysref_sync_delay_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
	compares++; \
	if ((got) !== (ex)) \
	begin \
		failures++; \
		$display("unexpected %s expected %h seen %h", nm, ex, got); \
	end
module sysref_sync_delay_control_bench;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [7:0]  addr_in = 8'h00;
	logic [7:0]  wdata_in = 8'h00;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic        sync_request_input_in = 1'b0;
	logic        input_level_good_flag_in = 1'b0;
	logic        clear = 1'b1;
	logic [3:0]  sel = 4'h0;
	wire  [7:0]  rdata_out;
	wire         stat_out;
	wire  [10:0] clk_out;
	wire         irq_out;
	wire  [15:0] rises;
	wire  [15:0] first;
	int          failures = 0;
	int          compares = 0;
	logic [15:0] t0;
	logic [15:0] t1;
	// Free-running clock.
	always #5 clk_in = ~clk_in;
	ssdc_top ssdc_top_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.sync_request_input_in(sync_request_input_in), .stat_out(stat_out),
		.input_level_good_flag_in(input_level_good_flag_in), .clk_out(clk_out),
		.irq_out(irq_out));
	ssdc_partner ssdc_partner_inst (.clk_in(clk_in), .clear_in(clear), .sel_in(sel),
		.lines_in(clk_out), .rises_out(rises), .first_out(first));
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] ex);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		`CHK("rdata_out", ex, rdata_out)
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic wipe;
		@(posedge clk_in);
		clear <= 1'b1;
		@(posedge clk_in);
		clear <= 1'b0;
	endtask
	// Software request pulse with the request pin held low, then a fresh count.
	task automatic meas(input logic [3:0] s, input logic [7:0] m, output logic [15:0] t);
		sel <= s;
		wr(8'h0b, m | 8'h01);
		wr(8'h0b, m);
		wipe();
		idle(80);
		t = first;
	endtask
	task automatic t_regs;
		rd(8'h01, 8'h00);
		rd(8'h0c, 8'h01);
		rd(8'h38, 8'h00);
		wr(8'h02, 8'h00);
		wr(8'h03, 8'h00);
		wr(8'h04, 8'h00);
		wr(8'h05, 8'h00);
		wr(8'h0b, 8'h04);
		rd(8'h0b, 8'h04);
		wr(8'h06, 8'h5a);
		rd(8'h06, 8'h00);
		rd(8'h0f, 8'h00);
	endtask
	task automatic t_stat;
		wr(8'h3a, 8'h04);
		wr(8'h01, 8'h08);
		input_level_good_flag_in <= 1'b1;
		idle(12);
		`CHK("stat high", 1'b1, stat_out)
		@(posedge clk_in);
		input_level_good_flag_in <= 1'b0;
		idle(12);
		`CHK("stat low", 1'b0, stat_out)
		rd(8'h38, 8'h04);
		wr(8'h39, 8'h04);
		wr(8'h01, 8'h00);
		input_level_good_flag_in <= 1'b1;
		idle(12);
		`CHK("stat masked", 1'b0, stat_out)
		rd(8'h38, 8'h00);
	endtask
	// Device clock on output 0 and its SYSREF on output 1 as controller, then output 0 again with the follower offset.
	task automatic t_delay;
		wr(8'h0c, 8'h02);
		wr(8'h0d, 8'h80);
		wr(8'h0e, 8'h10);
		wr(8'h10, 8'h02);
		wr(8'h11, 8'h90);
		wr(8'h12, 8'h0e);
		wr(8'h3a, 8'h01);
		meas(4'h1, 8'h04, t0);
		`CHK("irq sync", 1'b1, irq_out)
		`CHK("sysref first", 16'h000f, t0)
		rd(8'h38, 8'h01);
		wr(8'h39, 8'h01);
		rd(8'h38, 8'h00);
		wr(8'h3a, 8'h00);
		meas(4'h0, 8'h04, t1);
		`CHK("irq masked", 1'b0, irq_out)
		`CHK("delay step", 16'h0002, t1 - t0)
		meas(4'h0, 8'h14, t0);
		`CHK("follower lag", 16'h000e, t0 - t1)
		wr(8'h02, 8'h01);
		meas(4'h0, 8'h04, t0);
		`CHK("stopped", 16'hffff, t0)
		wr(8'h02, 8'h00);
		wr(8'h14, 8'h01);
		wr(8'h15, 8'hb0);
		wr(8'h19, 8'ha0);
		wr(8'h1a, 8'h0e);
		meas(4'h2, 8'h04, t0);
	endtask
	// One SYSREF request in pulsed mode; old status bits are cleared first.
	task automatic burst(input logic [2:0] e);
		wipe();
		wr(8'h39, 8'h07);
		wr(8'h0b, {2'b00, 1'b1, 1'b0, e, 1'b1});
		wr(8'h0b, {2'b00, 1'b1, 1'b0, e, 1'b0});
		idle(300);
		`CHK("burst rises", 16'h0001 << e, rises)
		`CHK("burst end", 1'b0, clk_out[2])
		rd(8'h38, 8'h02);
	endtask
	task automatic t_pass;
		sync_request_input_in <= 1'b1;
		idle(12);
		`CHK("pass high", 1'b1, clk_out[3])
		@(posedge clk_in);
		sync_request_input_in <= 1'b0;
		idle(12);
		`CHK("pass low", 1'b0, clk_out[3])
	endtask
	task automatic tally_and_finish;
		if (failures == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Main sequence.
	initial
	begin
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_regs();
		t_stat();
		t_delay();
		for (int e = 0; e < 8; e++)
			burst(e[2:0]);
		@(posedge clk_in);
		t_pass();
		tally_and_finish();
	end
	// Watchdog against a hang.
	initial
	begin
		repeat (20000) @(posedge clk_in);
		failures++;
		tally_and_finish();
	end
endmodule // sysref_sync_delay_control_bench
`default_nettype wire
